// *** core/ssc_map.vh ***
/*
  Bit positions, field codes and reset values for the stall stop and compare select block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SSC_MAP_VH
`define SSC_MAP_VH
`define SSC_BIT_ENC_SEL       25
`define SSC_BIT_STALL_HALT    26
`define SSC_BIT_POST_STALL    27
`define SSC_FLD_CMP_SRC_HI    29
`define SSC_FLD_CMP_SRC_LO    28
`define SSC_BIT_COVER_AUTO    30
`define SSC_SRC_COMPARE       2'h0
`define SSC_SRC_HOME          2'h1
`define SSC_SRC_LATCH         2'h2
`define SSC_SRC_REVOLUTION    2'h3
`define SSC_CFG_RESET         32'h00000000
`define SSC_POS_WIDTH         32
`endif

// *** core/ssc_cmp_unit.v ***
/*
  Registered equality compare of a position against a selected reference.
  Assumes synchronous inputs on one clock.
*/
`timescale 1ns/1ps
`include "ssc_map.vh"
module ssc_cmp_unit (
  // Clocking.
  input  wire                      clock,
  input  wire                      reset,
  input  wire                      clockEnable,
  // Operands.
  input  wire [`SSC_POS_WIDTH-1:0] position,
  input  wire [`SSC_POS_WIDTH-1:0] reference,
  // Result.
  output reg                       equal_reg
);
  always @(posedge clock) begin
    if (reset) begin
      equal_reg <= 1'b0;
    end else if (clockEnable) begin
      equal_reg <= (position == reference);
    end
  end
endmodule // ssc_cmp_unit

// *** core/ssc_stall_compare.v ***
/*
  Stall stop control, compare source selection and cover datagram trigger.
  Assumes stall events, positions and velocity come synchronous from the ramp and encoder logic.
*/
// Behaviour
// - Stall-halt bit stops outputs on stall unless permit bit is set
// - Permit bit allows motion during stall stop
// - Field 29:28 selects compare reference
// - Bit 30 enables automatic cover datagrams
// - Bit 25 selects encoder versus internal position
`timescale 1ns/1ps
`include "ssc_map.vh"
module ssc_stall_compare (
  // Clocking.
  input  wire                      clock,
  input  wire                      reset,
  input  wire                      clockEnable,
  // Configuration word.
  input  wire [31:0]               configWord,
  // Stall handling.
  input  wire                      stallEvent,
  input  wire                      stallClear,
  input  wire                      motionRequest,
  // Positions.
  input  wire [`SSC_POS_WIDTH-1:0] internalActualPosition,
  input  wire [`SSC_POS_WIDTH-1:0] encoderPosition,
  input  wire [`SSC_POS_WIDTH-1:0] compareValue,
  input  wire [`SSC_POS_WIDTH-1:0] homeReference,
  input  wire [`SSC_POS_WIDTH-1:0] latchedInternalPosition,
  input  wire [`SSC_POS_WIDTH-1:0] latchedEncoderPosition,
  input  wire [`SSC_POS_WIDTH-1:0] revolutionCounter,
  // Velocity.
  input  wire [`SSC_POS_WIDTH-1:0] presentVelocity,
  input  wire [`SSC_POS_WIDTH-1:0] coverThreshold,
  // Results.
  output reg                       stallStop_reg,
  output reg                       outputsEnable_reg,
  output reg                       motionAllow_reg,
  output reg                       compareHit_reg,
  output reg                       compareReached_reg,
  output reg                       coverRequest_reg
);
  wire                      encSel     = configWord[`SSC_BIT_ENC_SEL];
  wire                      stallHalt  = configWord[`SSC_BIT_STALL_HALT];
  wire                      postPermit = configWord[`SSC_BIT_POST_STALL];
  wire                      coverAuto  = configWord[`SSC_BIT_COVER_AUTO];
  wire [1:0]                cmpSrc     = configWord[`SSC_FLD_CMP_SRC_HI:`SSC_FLD_CMP_SRC_LO];
  reg  [`SSC_POS_WIDTH-1:0] cmpPos;
  reg  [`SSC_POS_WIDTH-1:0] cmpRef;
  reg                       stallStop_next;
  reg                       aboveLast_reg;
  reg                       hitPrev_reg;
  wire                      equalNow;
  wire                      aboveNow   = presentVelocity >= coverThreshold;

  always @* begin
    cmpPos = encSel ? encoderPosition : internalActualPosition;
  end

  always @* begin
    case (cmpSrc)
      `SSC_SRC_COMPARE: cmpRef = compareValue;
      `SSC_SRC_HOME:    cmpRef = homeReference;
      `SSC_SRC_LATCH:   cmpRef = encSel ? latchedEncoderPosition : latchedInternalPosition;
      default:          cmpRef = revolutionCounter;
    endcase
  end

  ssc_cmp_unit cmpUnit (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .position    (cmpPos),
    .reference   (cmpRef),
    .equal_reg   (equalNow)
  );

  // latch stall stop, set wins over clear
  always @* begin
    stallStop_next = stallStop_reg;
    if (stallClear) begin
      stallStop_next = 1'b0;
    end
    if (stallEvent && stallHalt) begin
      stallStop_next = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      stallStop_reg      <= 1'b0;
      outputsEnable_reg  <= 1'b1;
      motionAllow_reg    <= 1'b0;
      compareHit_reg     <= 1'b0;
      compareReached_reg <= 1'b0;
      coverRequest_reg   <= 1'b0;
      aboveLast_reg      <= 1'b0;
      hitPrev_reg        <= 1'b0;
    end else if (clockEnable) begin
      stallStop_reg      <= stallStop_next;
      outputsEnable_reg  <= ~stallStop_next | postPermit;
      motionAllow_reg    <= motionRequest & (~stallStop_next | postPermit);
      compareHit_reg     <= equalNow;
      hitPrev_reg        <= equalNow;
      compareReached_reg <= equalNow & ~hitPrev_reg;
      aboveLast_reg      <= aboveNow;
      coverRequest_reg   <= coverAuto & (aboveNow ^ aboveLast_reg);
    end
  end
endmodule // ssc_stall_compare

// *** tb/ssc_monitor.sv ***
/* Port checker for ssc_stall_compare; bound from the bench top file. */
`timescale 1ns/1ps
module ssc_monitor (
  input wire logic clock, reset, clockEnable, stallEvent, stallClear, motionRequest, stallStop_reg,
  input wire logic outputsEnable_reg, motionAllow_reg, compareHit_reg, compareReached_reg, coverRequest_reg,
  input wire logic [31:0] configWord, internalActualPosition, encoderPosition, compareValue
);
  wire hold = clockEnable && stallStop_reg && !stallClear && !configWord[27];
  wire src0 = clockEnable && configWord[29:28] == 2'h0 &&
              compareValue == (configWord[25] ? encoderPosition : internalActualPosition);
  wire eqInt = clockEnable && configWord[29:28] == 2'h0 && !configWord[25] && internalActualPosition == compareValue;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_HALT: assert property (clockEnable && stallEvent && configWord[26] |=> stallStop_reg) else $error("no halt");
  AST_OUTOFF: assert property (hold |=> !outputsEnable_reg) else $error("outputs run");
  AST_BLOCK: assert property (hold |=> !motionAllow_reg) else $error("motion run");
  AST_PERMIT: assert property (clockEnable && configWord[27] && motionRequest |=> motionAllow_reg) else $error("held");
  AST_SRC: assert property (eqInt [*2] |=> compareHit_reg) else $error("no hit");
  AST_ENC: assert property (src0 [*2] |=> compareHit_reg) else $error("no encoder hit");
  AST_EDGE: assert property (compareReached_reg && $past(clockEnable) |-> !$past(compareHit_reg)) else $error("edge");
  AST_NOCOV: assert property (clockEnable && !configWord[30] |=> !coverRequest_reg) else $error("cover");
  AST_FREEZE: assert property (!clockEnable |=> $stable(coverRequest_reg) && $stable(stallStop_reg)) else $error("freeze");
  cover property (stallStop_reg);
  cover property (compareReached_reg);
  cover property (coverRequest_reg);
endmodule // ssc_monitor

// *** tb/ssc_driver_model.sv ***
/* Stepper driver stand-in counting cover datagrams; fed by ssc_stall_compare. */
`timescale 1ns/1ps
module ssc_driver_model (
  input wire logic clock,
  input wire logic coverRequest_reg,
  output int       datagrams = 0
);
  always @(posedge clock) datagrams <= datagrams + (coverRequest_reg ? 1 : 0);
endmodule // ssc_driver_model

// *** tb/ssc_stall_compare_tb.sv ***
/* Bench for ssc_stall_compare; assumes monitor and driver model compiled first. */
`timescale 1ns/1ps
module ssc_stall_compare_tb;
  logic clock = 0, reset = 1, clockEnable = 1, stallEvent = 0, stallClear = 0, motionRequest = 0;
  logic [31:0] configWord = 32'h0, internalActualPosition = 32'h5, encoderPosition = 32'h6, compareValue = 32'h0;
  logic [31:0] homeReference = 32'h0, latchedInternalPosition = 32'h0, latchedEncoderPosition = 32'h7;
  logic [31:0] revolutionCounter = 32'h0, presentVelocity = 32'h0, coverThreshold = 32'h5;
  logic stallStop_reg, outputsEnable_reg, motionAllow_reg, compareHit_reg, compareReached_reg, coverRequest_reg;
  int bad_count = 0, compares = 0, datagrams, i;
  always #20 clock = ~clock;
  ssc_stall_compare ssc_stall_compare_i (.*);
  ssc_driver_model ssc_driver_model_i (.*);
  task automatic step(input int n); repeat (n) @(negedge clock); endtask
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    step(6); reset = 0; stallEvent = 1; step(2); stallEvent = 0;
    chk({stallStop_reg, outputsEnable_reg}, 32'h1);
    configWord[26] = 1; motionRequest = 1; stallEvent = 1; step(1); stallEvent = 0; step(1);
    chk({stallStop_reg, outputsEnable_reg, motionAllow_reg}, 32'h4);
    configWord[27] = 1; step(2);
    chk(motionAllow_reg, 32'h1);
    stallClear = 1; step(1); stallClear = 0;
    chk(stallStop_reg, 32'h0);
    for (i = 0; i < 4; i++) begin
      configWord[29:28] = i[1:0]; compareValue = i == 0 ? 32'h5 : 32'h7; homeReference = i == 1 ? 32'h5 : 32'h7;
      latchedInternalPosition = i == 2 ? 32'h5 : 32'h7; revolutionCounter = i == 3 ? 32'h5 : 32'h7;
      internalActualPosition = 32'h6; step(3);
      chk(compareHit_reg, 32'h0);
      internalActualPosition = 32'h5; step(2);
      chk({compareHit_reg, compareReached_reg}, 32'h3);
    end
    configWord[29:25] = 5'h1; compareValue = 32'h5; encoderPosition = 32'h5; internalActualPosition = 32'h6; step(3);
    chk(compareHit_reg, 32'h1);
    presentVelocity = 32'hA; step(2);
    chk(coverRequest_reg, 32'h0);
    configWord[30] = 1; presentVelocity = 32'h0; step(1);
    chk(coverRequest_reg, 32'h1);
    presentVelocity = 32'hA; step(1);
    chk(coverRequest_reg, 32'h1);
    step(1);
    chk({datagrams[3:0], coverRequest_reg}, 32'h4);
    clockEnable = 0; presentVelocity = 32'h0; step(2);
    chk(coverRequest_reg, 32'h0);
    clockEnable = 1; step(1);
    chk(coverRequest_reg, 32'h1);
    end_sim;
  end
endmodule // ssc_stall_compare_tb
bind ssc_stall_compare ssc_monitor ssc_monitor_i (.*);
